// ===== include/sucr_pkg.sv
// Purpose: constants and types for the upper configuration register bank
// Assumes: 8-bit register access port, byte addresses 0x68..0x7e
// Notes: all offsets, reset values and single-bit field positions live here, except pad drive bits 3 and 7
package sucr_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] SUCR_AUX_PAD_TRIM = 8'h68;
	localparam logic [7:0] SUCR_NV_PROG_CONFIG = 8'h6a;
	localparam logic [7:0] SUCR_SERIAL_PORT = 8'h6b;
	localparam logic [7:0] SUCR_PAD_DRIVE = 8'h6c;
	localparam logic [7:0] SUCR_ACC_SELFTEST = 8'h6d;
	localparam logic [7:0] SUCR_GYR_SELFTEST = 8'h6e;
	localparam logic [7:0] SUCR_NV_BACKED = 8'h70;
	localparam logic [7:0] SUCR_ACC_X_OFF = 8'h71;
	localparam logic [7:0] SUCR_ACC_Y_OFF = 8'h72;
	localparam logic [7:0] SUCR_ACC_Z_OFF = 8'h73;
	localparam logic [7:0] SUCR_GYR_X_OFF = 8'h74;
	localparam logic [7:0] SUCR_GYR_Y_OFF = 8'h75;
	localparam logic [7:0] SUCR_GYR_Z_OFF = 8'h76;
	localparam logic [7:0] SUCR_GYR_OFF_HI = 8'h77;
	localparam logic [7:0] SUCR_POWER_CONF = 8'h7c;
	localparam logic [7:0] SUCR_POWER_CTRL = 8'h7d;
	localparam logic [7:0] SUCR_COMMAND = 8'h7e;

	// ----------------------------------------
	// reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] SUCR_RST_AUX_PAD_TRIM = 8'h01;
	localparam logic [7:0] SUCR_RST_PAD_DRIVE = 8'hff;
	localparam logic [7:0] SUCR_RST_POWER_CONF = 8'h03;
	localparam logic [7:0] SUCR_RST_ZERO = 8'h00;
	localparam logic [7:0] SUCR_MSK_AUX_PAD_TRIM = 8'h03;
	localparam logic [7:0] SUCR_MSK_NV_PROG_CONFIG = 8'h02;
	localparam logic [7:0] SUCR_MSK_SERIAL_PORT = 8'h33;
	localparam logic [7:0] SUCR_MSK_ACC_SELFTEST = 8'h0d;
	localparam logic [7:0] SUCR_MSK_NV_BACKED = 8'h0f;
	localparam logic [7:0] SUCR_MSK_POWER_CONF = 8'h07;
	localparam logic [7:0] SUCR_MSK_POWER_CTRL = 8'h0f;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] SUCR_CMD_NV_PROG = 8'ha0;
	localparam logic [7:0] SUCR_CMD_FIFO_FLUSH = 8'hb0;
	localparam logic [7:0] SUCR_CMD_SOFT_RESET = 8'hb6;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SUCR_BIT_NV_PROG_EN = 1;
	localparam int SUCR_BIT_PRI_3W = 0;
	localparam int SUCR_BIT_STAB_3W = 1;
	localparam int SUCR_BIT_STAB_EN = 4;
	localparam int SUCR_BIT_AUX_EN = 5;
	localparam int SUCR_BIT_SPI_EN = 0;
	localparam int SUCR_BIT_WDT_SEL = 1;
	localparam int SUCR_BIT_WDT_EN = 2;
	localparam int SUCR_BIT_ACC_OFF_EN = 3;
	localparam int SUCR_BIT_GYR_OFF_EN = 6;
	localparam int SUCR_BIT_GYR_GAIN_EN = 7;
	localparam int SUCR_BIT_ADV_PS = 0;
	localparam int SUCR_BIT_FIFO_WAKE = 1;
	localparam int SUCR_BIT_FAST_UP = 2;
	localparam int SUCR_BIT_ST_EN = 0;
	localparam int SUCR_BIT_ST_SIGN = 2;
	localparam int SUCR_BIT_ST_AMP = 3;

	// ----------------------------------------
	// watchdog timing
	// ----------------------------------------
	localparam int SUCR_CLK_HZ = 25000000;
	localparam int SUCR_WDT_SHORT_US = 1250;
	localparam int SUCR_WDT_LONG_US = 40000;
	localparam int SUCR_WDT_SHORT_CYC = SUCR_WDT_SHORT_US * (SUCR_CLK_HZ / 1000000);
	localparam int SUCR_WDT_LONG_CYC = SUCR_WDT_LONG_US * (SUCR_CLK_HZ / 1000000);
	localparam int SUCR_WDT_W = 20;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sucr_req_t;

	typedef struct packed {
		logic done;
		logic x_ok;
		logic y_ok;
		logic z_ok;
	} sucr_gyr_st_t;

	typedef struct packed {
		logic [1:0] aux_pullup_sel;
		logic [2:0] pad_strength_group_one;
		logic pad_i2c_strength_bit_one;
		logic [2:0] pad_strength_group_two;
		logic pad_i2c_strength_bit_two;
		logic primary_three_wire_select;
		logic stabilizer_three_wire_select;
		logic aux_port_on;
		logic stabilizer_port_on;
		logic i2c_disabled;
		logic [2:0] acc_st_ctrl;
		logic adv_power_save;
		logic fifo_read_in_lowpower;
		logic fast_power_up;
		logic [3:0] sensor_enables;
		logic acc_off_en;
		logic gyr_off_en;
		logic gyr_gain_en;
		logic [23:0] acc_offsets;
		logic [29:0] gyr_offsets;
	} sucr_cfg_t;

endpackage

// ===== verilog/sucr_regs.sv
// Purpose: upper configuration register bank with command decoding
// Assumes: register port already decoded from the serial interface
// Notes: one register cycle per access, read data one cycle later
`timescale 1ns/10ps

// What this block does
// - command register always reads zero
// - code b0 pulses fifo flush
// - code b6 restores all defaults
// - code a0 starts nonvolatile program
// - bit0 selects primary three-wire spi
// - bit1 selects stabilizer three-wire spi
// - aux port wins over stabilizer port
// - spi_en in autoconfig disables i2c
// - watchdog 1.25 ms or 40 ms
// - watchdog runs on data pin in i2c
// - accel offset enable drives offset adding
// - gyro offsets ten bits, split high field
// - gyro offset enable drives offset adding
// - bit7 enables gyro gain compensation
// - power save bit, resets 0x03
// - fifo wake bit permits lowpower reads
// - fast power up bit, reset clear
// - power control enables four sources
// - self-test enable, sign, amplitude bits
// - gyro self-test status read-only
// - two-bit pull-up select, resets one
// - drive strength register resets all ones
module sucr_regs (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire sucr_pkg::sucr_req_t req,
	input wire sucr_pkg::sucr_gyr_st_t gyr_st,
	input wire logic autoconfig_mode,
	input wire logic i2c_mode,
	input wire logic sda_activity,
	output logic [7:0] rdata,
	output sucr_pkg::sucr_cfg_t cfg,
	output logic fifo_flush,
	output logic nv_prog_start,
	output logic soft_reset_pulse,
	output logic wdt_timeout
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] aux_pad_trim;
	logic [7:0] nonvolatile_program_config;
	logic [7:0] serial_port_settings;
	logic [7:0] pad_drive_strength;
	logic [7:0] accel_selftest_control;
	logic [7:0] nonvolatile_backed_config;
	logic [7:0] accel_x_offset;
	logic [7:0] accel_y_offset;
	logic [7:0] accel_z_offset;
	logic [7:0] gyro_x_offset_low;
	logic [7:0] gyro_y_offset_low;
	logic [7:0] gyro_z_offset_low;
	logic [7:0] gyro_offset_high_and_enables;
	logic [7:0] power_configuration;
	logic [7:0] power_control;
	logic [7:0] next_rdata;
	logic wr_cmd;
	logic soft_rst;
	logic [sucr_pkg::SUCR_WDT_W-1:0] wdt_count;
	logic [sucr_pkg::SUCR_WDT_W-1:0] wdt_limit;
	logic wdt_active;

	assign wr_cmd = req.wr && (req.addr == sucr_pkg::SUCR_COMMAND);
	assign soft_rst = wr_cmd && (req.wdata == sucr_pkg::SUCR_CMD_SOFT_RESET);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aux_pad_trim <= sucr_pkg::SUCR_RST_AUX_PAD_TRIM;
			nonvolatile_program_config <= sucr_pkg::SUCR_RST_ZERO;
			serial_port_settings <= sucr_pkg::SUCR_RST_ZERO;
			pad_drive_strength <= sucr_pkg::SUCR_RST_PAD_DRIVE;
			accel_selftest_control <= sucr_pkg::SUCR_RST_ZERO;
			nonvolatile_backed_config <= sucr_pkg::SUCR_RST_ZERO;
			accel_x_offset <= sucr_pkg::SUCR_RST_ZERO;
			accel_y_offset <= sucr_pkg::SUCR_RST_ZERO;
			accel_z_offset <= sucr_pkg::SUCR_RST_ZERO;
			gyro_x_offset_low <= sucr_pkg::SUCR_RST_ZERO;
			gyro_y_offset_low <= sucr_pkg::SUCR_RST_ZERO;
			gyro_z_offset_low <= sucr_pkg::SUCR_RST_ZERO;
			gyro_offset_high_and_enables <= sucr_pkg::SUCR_RST_ZERO;
			power_configuration <= sucr_pkg::SUCR_RST_POWER_CONF;
			power_control <= sucr_pkg::SUCR_RST_ZERO;
		end else if (soft_rst) begin
			aux_pad_trim <= sucr_pkg::SUCR_RST_AUX_PAD_TRIM;
			nonvolatile_program_config <= sucr_pkg::SUCR_RST_ZERO;
			serial_port_settings <= sucr_pkg::SUCR_RST_ZERO;
			pad_drive_strength <= sucr_pkg::SUCR_RST_PAD_DRIVE;
			accel_selftest_control <= sucr_pkg::SUCR_RST_ZERO;
			nonvolatile_backed_config <= sucr_pkg::SUCR_RST_ZERO;
			accel_x_offset <= sucr_pkg::SUCR_RST_ZERO;
			accel_y_offset <= sucr_pkg::SUCR_RST_ZERO;
			accel_z_offset <= sucr_pkg::SUCR_RST_ZERO;
			gyro_x_offset_low <= sucr_pkg::SUCR_RST_ZERO;
			gyro_y_offset_low <= sucr_pkg::SUCR_RST_ZERO;
			gyro_z_offset_low <= sucr_pkg::SUCR_RST_ZERO;
			gyro_offset_high_and_enables <= sucr_pkg::SUCR_RST_ZERO;
			power_configuration <= sucr_pkg::SUCR_RST_POWER_CONF;
			power_control <= sucr_pkg::SUCR_RST_ZERO;
		end else if (req.wr) begin
			unique case (req.addr)
				sucr_pkg::SUCR_AUX_PAD_TRIM: aux_pad_trim <= req.wdata & sucr_pkg::SUCR_MSK_AUX_PAD_TRIM;
				sucr_pkg::SUCR_NV_PROG_CONFIG: nonvolatile_program_config <= req.wdata & sucr_pkg::SUCR_MSK_NV_PROG_CONFIG;
				sucr_pkg::SUCR_SERIAL_PORT: serial_port_settings <= req.wdata & sucr_pkg::SUCR_MSK_SERIAL_PORT;
				sucr_pkg::SUCR_PAD_DRIVE: pad_drive_strength <= req.wdata;
				sucr_pkg::SUCR_ACC_SELFTEST: accel_selftest_control <= req.wdata & sucr_pkg::SUCR_MSK_ACC_SELFTEST;
				sucr_pkg::SUCR_NV_BACKED: nonvolatile_backed_config <= req.wdata & sucr_pkg::SUCR_MSK_NV_BACKED;
				sucr_pkg::SUCR_ACC_X_OFF: accel_x_offset <= req.wdata;
				sucr_pkg::SUCR_ACC_Y_OFF: accel_y_offset <= req.wdata;
				sucr_pkg::SUCR_ACC_Z_OFF: accel_z_offset <= req.wdata;
				sucr_pkg::SUCR_GYR_X_OFF: gyro_x_offset_low <= req.wdata;
				sucr_pkg::SUCR_GYR_Y_OFF: gyro_y_offset_low <= req.wdata;
				sucr_pkg::SUCR_GYR_Z_OFF: gyro_z_offset_low <= req.wdata;
				sucr_pkg::SUCR_GYR_OFF_HI: gyro_offset_high_and_enables <= req.wdata;
				sucr_pkg::SUCR_POWER_CONF: power_configuration <= req.wdata & sucr_pkg::SUCR_MSK_POWER_CONF;
				sucr_pkg::SUCR_POWER_CTRL: power_control <= req.wdata & sucr_pkg::SUCR_MSK_POWER_CTRL;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		unique case (req.addr)
			sucr_pkg::SUCR_AUX_PAD_TRIM: next_rdata = aux_pad_trim;
			sucr_pkg::SUCR_NV_PROG_CONFIG: next_rdata = nonvolatile_program_config;
			sucr_pkg::SUCR_SERIAL_PORT: next_rdata = serial_port_settings;
			sucr_pkg::SUCR_PAD_DRIVE: next_rdata = pad_drive_strength;
			sucr_pkg::SUCR_ACC_SELFTEST: next_rdata = accel_selftest_control;
			sucr_pkg::SUCR_GYR_SELFTEST: next_rdata = {4'h0, gyr_st.z_ok, gyr_st.y_ok, gyr_st.x_ok, gyr_st.done};
			sucr_pkg::SUCR_NV_BACKED: next_rdata = nonvolatile_backed_config;
			sucr_pkg::SUCR_ACC_X_OFF: next_rdata = accel_x_offset;
			sucr_pkg::SUCR_ACC_Y_OFF: next_rdata = accel_y_offset;
			sucr_pkg::SUCR_ACC_Z_OFF: next_rdata = accel_z_offset;
			sucr_pkg::SUCR_GYR_X_OFF: next_rdata = gyro_x_offset_low;
			sucr_pkg::SUCR_GYR_Y_OFF: next_rdata = gyro_y_offset_low;
			sucr_pkg::SUCR_GYR_Z_OFF: next_rdata = gyro_z_offset_low;
			sucr_pkg::SUCR_GYR_OFF_HI: next_rdata = gyro_offset_high_and_enables;
			sucr_pkg::SUCR_POWER_CONF: next_rdata = power_configuration;
			sucr_pkg::SUCR_POWER_CTRL: next_rdata = power_control;
			sucr_pkg::SUCR_COMMAND: next_rdata = 8'h00;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// command pulses
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fifo_flush <= 1'b0;
			nv_prog_start <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end else begin
			fifo_flush <= wr_cmd && (req.wdata == sucr_pkg::SUCR_CMD_FIFO_FLUSH);
			nv_prog_start <= wr_cmd && (req.wdata == sucr_pkg::SUCR_CMD_NV_PROG)
				&& nonvolatile_program_config[sucr_pkg::SUCR_BIT_NV_PROG_EN];
			soft_reset_pulse <= soft_rst;
		end
	end

	// ----------------------------------------
	// configuration outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg <= '0;
		end else begin
			cfg.aux_pullup_sel <= aux_pad_trim[1:0];
			cfg.pad_strength_group_one <= pad_drive_strength[2:0];
			cfg.pad_i2c_strength_bit_one <= pad_drive_strength[3];
			cfg.pad_strength_group_two <= pad_drive_strength[6:4];
			cfg.pad_i2c_strength_bit_two <= pad_drive_strength[7];
			cfg.primary_three_wire_select <= serial_port_settings[sucr_pkg::SUCR_BIT_PRI_3W];
			cfg.stabilizer_three_wire_select <= serial_port_settings[sucr_pkg::SUCR_BIT_STAB_3W]
				&& serial_port_settings[sucr_pkg::SUCR_BIT_STAB_EN];
			cfg.aux_port_on <= serial_port_settings[sucr_pkg::SUCR_BIT_AUX_EN];
			cfg.stabilizer_port_on <= serial_port_settings[sucr_pkg::SUCR_BIT_STAB_EN]
				&& !serial_port_settings[sucr_pkg::SUCR_BIT_AUX_EN];
			cfg.i2c_disabled <= autoconfig_mode && nonvolatile_backed_config[sucr_pkg::SUCR_BIT_SPI_EN];
			cfg.acc_st_ctrl <= {accel_selftest_control[sucr_pkg::SUCR_BIT_ST_AMP],
				accel_selftest_control[sucr_pkg::SUCR_BIT_ST_SIGN],
				accel_selftest_control[sucr_pkg::SUCR_BIT_ST_EN]};
			cfg.adv_power_save <= power_configuration[sucr_pkg::SUCR_BIT_ADV_PS];
			cfg.fifo_read_in_lowpower <= power_configuration[sucr_pkg::SUCR_BIT_FIFO_WAKE];
			cfg.fast_power_up <= power_configuration[sucr_pkg::SUCR_BIT_FAST_UP];
			cfg.sensor_enables <= power_control[3:0];
			cfg.acc_off_en <= nonvolatile_backed_config[sucr_pkg::SUCR_BIT_ACC_OFF_EN];
			cfg.gyr_off_en <= gyro_offset_high_and_enables[sucr_pkg::SUCR_BIT_GYR_OFF_EN];
			cfg.gyr_gain_en <= gyro_offset_high_and_enables[sucr_pkg::SUCR_BIT_GYR_GAIN_EN];
			cfg.acc_offsets <= {accel_z_offset, accel_y_offset, accel_x_offset};
			cfg.gyr_offsets <= {gyro_offset_high_and_enables[5:4], gyro_z_offset_low,
				gyro_offset_high_and_enables[3:2], gyro_y_offset_low,
				gyro_offset_high_and_enables[1:0], gyro_x_offset_low};
		end
	end

	// ----------------------------------------
	// i2c watchdog on the data pin
	// ----------------------------------------
	assign wdt_active = nonvolatile_backed_config[sucr_pkg::SUCR_BIT_WDT_EN] && i2c_mode;
	assign wdt_limit = nonvolatile_backed_config[sucr_pkg::SUCR_BIT_WDT_SEL]
		? sucr_pkg::SUCR_WDT_W'(sucr_pkg::SUCR_WDT_LONG_CYC)
		: sucr_pkg::SUCR_WDT_W'(sucr_pkg::SUCR_WDT_SHORT_CYC);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wdt_count <= '0;
			wdt_timeout <= 1'b0;
		end else if (!wdt_active || !sda_activity) begin
			wdt_count <= '0;
			wdt_timeout <= 1'b0;
		end else if (wdt_count >= wdt_limit - 1'b1) begin
			wdt_count <= '0;
			wdt_timeout <= 1'b1;
		end else begin
			wdt_count <= wdt_count + 1'b1;
			wdt_timeout <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_cmd_reads_zero;
		@(posedge clk_sys) disable iff (!rstn)
		(req.rd && req.addr == sucr_pkg::SUCR_COMMAND) |=> (rdata == 8'h00);
	endproperty
	a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command read not zero");

	sequence s_flush_cmd;
		wr_cmd && (req.wdata == sucr_pkg::SUCR_CMD_FIFO_FLUSH);
	endsequence

	sequence s_flush_seen;
		$past(wr_cmd) && ($past(req.wdata) == sucr_pkg::SUCR_CMD_FIFO_FLUSH);
	endsequence

	property p_flush;
		@(posedge clk_sys) disable iff (!rstn)
		s_flush_cmd |=> fifo_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("flush pulse missing");

	property p_flush_cause;
		@(posedge clk_sys) disable iff (!rstn)
		fifo_flush |-> s_flush_seen;
	endproperty
	a_flush_cause: assert property (p_flush_cause) else $error("flush without command");

	sequence s_regs_default;
		power_configuration == sucr_pkg::SUCR_RST_POWER_CONF
			&& pad_drive_strength == sucr_pkg::SUCR_RST_PAD_DRIVE
			&& aux_pad_trim == sucr_pkg::SUCR_RST_AUX_PAD_TRIM
			&& power_control == sucr_pkg::SUCR_RST_ZERO
			&& serial_port_settings == sucr_pkg::SUCR_RST_ZERO
			&& nonvolatile_program_config == sucr_pkg::SUCR_RST_ZERO;
	endsequence

	sequence s_cfg_default;
		cfg.adv_power_save && cfg.fifo_read_in_lowpower && !cfg.fast_power_up
			&& cfg.sensor_enables == 4'h0 && cfg.aux_pullup_sel == 2'h1;
	endsequence

	property p_soft_reset;
		@(posedge clk_sys) disable iff (!rstn)
		soft_rst |=> s_regs_default ##1 s_cfg_default;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left settings");

	property p_soft_pulse;
		@(posedge clk_sys) disable iff (!rstn)
		soft_rst |=> soft_reset_pulse;
	endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse missing");

	property p_prog_gated;
		@(posedge clk_sys) disable iff (!rstn)
		nv_prog_start |-> $past(wr_cmd && req.wdata == sucr_pkg::SUCR_CMD_NV_PROG
			&& nonvolatile_program_config[sucr_pkg::SUCR_BIT_NV_PROG_EN]);
	endproperty
	a_prog_gated: assert property (p_prog_gated) else $error("program without enable");

	property p_prog_taken;
		@(posedge clk_sys) disable iff (!rstn)
		(wr_cmd && req.wdata == 8'ha0 && nonvolatile_program_config[1]) |=> nv_prog_start;
	endproperty
	a_prog_taken: assert property (p_prog_taken) else $error("program command lost");

	property p_prog_refused;
		@(posedge clk_sys) disable iff (!rstn)
		(wr_cmd && req.wdata == sucr_pkg::SUCR_CMD_NV_PROG
			&& !nonvolatile_program_config[sucr_pkg::SUCR_BIT_NV_PROG_EN]) |=> !nv_prog_start;
	endproperty
	a_prog_refused: assert property (p_prog_refused) else $error("program taken while disabled");

	property p_aux_priority;
		@(posedge clk_sys) disable iff (!rstn)
		cfg.aux_port_on |-> !cfg.stabilizer_port_on;
	endproperty
	a_aux_priority: assert property (p_aux_priority) else $error("both ports on");

	property p_i2c_off;
		@(posedge clk_sys) disable iff (!rstn)
		(autoconfig_mode && nonvolatile_backed_config[0]) |=> cfg.i2c_disabled;
	endproperty
	a_i2c_off: assert property (p_i2c_off) else $error("i2c not disabled");

	property p_i2c_on;
		@(posedge clk_sys) disable iff (!rstn)
		!(autoconfig_mode && nonvolatile_backed_config[sucr_pkg::SUCR_BIT_SPI_EN]) |=> !cfg.i2c_disabled;
	endproperty
	a_i2c_on: assert property (p_i2c_on) else $error("i2c disabled wrongly");

	property p_wdt_bound;
		@(posedge clk_sys) disable iff (!rstn)
		wdt_count < sucr_pkg::SUCR_WDT_W'(sucr_pkg::SUCR_WDT_LONG_CYC);
	endproperty
	a_wdt_bound: assert property (p_wdt_bound) else $error("watchdog count overrun");

	property p_wdt_idle;
		@(posedge clk_sys) disable iff (!rstn)
		!wdt_active |=> (wdt_count == '0 && !wdt_timeout);
	endproperty
	a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog ran while off");

	property p_wdt_step;
		@(posedge clk_sys) disable iff (!rstn)
		(wdt_active && sda_activity && wdt_count < wdt_limit - 1'b1)
			|=> wdt_count == $past(wdt_count) + 1'b1;
	endproperty
	a_wdt_step: assert property (p_wdt_step) else $error("watchdog count skipped");

	property p_wdt_fire;
		@(posedge clk_sys) disable iff (!rstn)
		wdt_timeout |-> $past(wdt_active) && $past(sda_activity)
			&& $past(wdt_count) >= $past(wdt_limit) - 1'b1;
	endproperty
	a_wdt_fire: assert property (p_wdt_fire) else $error("watchdog fired early");

	property p_gyr_high;
		@(posedge clk_sys) disable iff (!rstn)
		##2 cfg.gyr_offsets[29:28] == $past(gyro_offset_high_and_enables[5:4])
			&& cfg.gyr_offsets[19:18] == $past(gyro_offset_high_and_enables[3:2])
			&& cfg.gyr_offsets[9:8] == $past(gyro_offset_high_and_enables[1:0]);
	endproperty
	a_gyr_high: assert property (p_gyr_high) else $error("gyro high bits wrong");

	property p_stab_three_wire;
		@(posedge clk_sys) disable iff (!rstn)
		cfg.stabilizer_three_wire_select |-> $past(serial_port_settings[sucr_pkg::SUCR_BIT_STAB_EN]);
	endproperty
	a_stab_three_wire: assert property (p_stab_three_wire) else $error("three-wire while port off");

	property p_status_read;
		@(posedge clk_sys) disable iff (!rstn)
		(req.rd && req.addr == sucr_pkg::SUCR_GYR_SELFTEST) |=> rdata[7:4] == 4'h0
			&& rdata[3:0] == $past({gyr_st.z_ok, gyr_st.y_ok, gyr_st.x_ok, gyr_st.done});
	endproperty
	a_status_read: assert property (p_status_read) else $error("self-test status read wrong");

endmodule // sucr_regs

// ===== tb/sucr_host.sv
// Purpose: host processor model driving the register port of the bank
// Assumes: requests launched at the falling edge, taken at the next rising edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/10ps

module sucr_host (
	input wire logic clk_sys,
	input wire logic [7:0] rdata,
	output sucr_pkg::sucr_req_t req
);
	initial begin
		req = '0;
	end

	// ----------------------------------------
	// one register write, strobe held for one rising edge
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// ----------------------------------------
	// one register read, data taken once the strobe edge has passed
	// ----------------------------------------
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		d = rdata;
	endtask
endmodule // sucr_host

// ===== tb/sucr_regs_test.sv
// Purpose: self-checking bench for the upper configuration register bank
// Assumes: host model on the register port, array model of the registers
// Notes: watchdog checked with the short period only
`timescale 1ns/10ps

module sucr_regs_test;
	logic clk_sys, rstn, autoconfig_mode, i2c_mode, sda_activity;
	sucr_pkg::sucr_req_t req;
	sucr_pkg::sucr_gyr_st_t gyr_st;
	sucr_pkg::sucr_cfg_t cfg;
	logic [7:0] rdata, rv;
	logic [9:0] gv;
	logic fifo_flush, nv_prog_start, soft_reset_pulse, wdt_timeout;
	int bad_count = 0, checks = 0, n_fl = 0, n_pr = 0, n_sr = 0, n_wd = 0, e_fl = 0, e_pr = 0, e_sr = 0, n;
	logic [7:0] addrs [20] = '{8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71,
		8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h7c, 8'h7d, 8'h7e, 8'h7f};
	logic [7:0] mskv [20] = '{8'h03, 8'h00, 8'h02, 8'h33, 8'hff, 8'h0d, 8'h00, 8'h00, 8'h0f, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h0f, 8'h00, 8'h00};
	logic [7:0] rstv [20] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
	logic [7:0] mdl [20];

	sucr_regs u_sucr_regs (.clk_sys(clk_sys), .rstn(rstn), .req(req), .gyr_st(gyr_st),
		.autoconfig_mode(autoconfig_mode), .i2c_mode(i2c_mode), .sda_activity(sda_activity),
		.rdata(rdata), .cfg(cfg), .fifo_flush(fifo_flush), .nv_prog_start(nv_prog_start),
		.soft_reset_pulse(soft_reset_pulse), .wdt_timeout(wdt_timeout));

	sucr_host u_sucr_host (.clk_sys(clk_sys), .rdata(rdata), .req(req));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(negedge clk_sys) begin
		n_fl += (fifo_flush === 1'b1);
		n_pr += (nv_prog_start === 1'b1);
		n_sr += (soft_reset_pulse === 1'b1);
		n_wd += (wdt_timeout === 1'b1);
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic w(input int i, input logic [7:0] d);
		u_sucr_host.wr(addrs[i], d);
		mdl[i] = d & mskv[i];
		if (i == 18 && d == 8'hb0)
			e_fl++;
		if (i == 18 && d == 8'ha0 && mdl[2][1])
			e_pr++;
		if (i == 18 && d == 8'hb6) begin
			e_sr++;
			mdl = rstv;
		end
	endtask

	task automatic rd_all();
		for (int i = 0; i < 20; i++) begin
			u_sucr_host.rd(addrs[i], rv);
			check(rv, (i == 6) ? {4'h0, gyr_st.z_ok, gyr_st.y_ok, gyr_st.x_ok, gyr_st.done} : mdl[i]);
		end
	endtask

	task automatic cfg_chk();
		check(cfg.sensor_enables, mdl[17][3:0]);
		check(cfg.adv_power_save, mdl[16][0]);
		check(cfg.fifo_read_in_lowpower, mdl[16][1]);
		check(cfg.fast_power_up, mdl[16][2]);
		check(cfg.primary_three_wire_select, mdl[3][0]);
		if (!mdl[3][5]) check(cfg.stabilizer_three_wire_select, mdl[3][1] & mdl[3][4]);
		check(cfg.aux_port_on, mdl[3][5]);
		check(cfg.stabilizer_port_on, mdl[3][4] & ~mdl[3][5]);
		check(cfg.i2c_disabled, mdl[8][0] & autoconfig_mode);
		check(cfg.acc_off_en, mdl[8][3]);
		check(cfg.gyr_off_en, mdl[15][6]);
		check(cfg.gyr_gain_en, mdl[15][7]);
		check(cfg.aux_pullup_sel, mdl[0][1:0]);
		check(cfg.acc_st_ctrl, {mdl[5][3], mdl[5][2], mdl[5][0]});
		check(cfg.acc_offsets, {mdl[11], mdl[10], mdl[9]});
		check(cfg.gyr_offsets, {mdl[15][5:4], mdl[14], mdl[15][3:2], mdl[13], mdl[15][1:0], mdl[12]});
		check({cfg.pad_i2c_strength_bit_two, cfg.pad_strength_group_two, cfg.pad_i2c_strength_bit_one,
			cfg.pad_strength_group_one}, mdl[4]);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h54d6_d4e6));
		rstn = 1'b0;
		autoconfig_mode = 1'b0;
		i2c_mode = 1'b0;
		sda_activity = 1'b0;
		gyr_st = '0;
		mdl = rstv;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		repeat (2) @(negedge clk_sys);
		cfg_chk();
		rd_all();
		for (int k = 0; k < 12; k++) begin
			@(negedge clk_sys);
			gyr_st = 4'($urandom);
			autoconfig_mode = 1'($urandom);
			for (int i = 0; i < 18; i++)
				w(i, 8'($urandom));
			repeat (3) @(negedge clk_sys);
			cfg_chk();
			rd_all();
		end
		for (int k = 0; k < 4; k++) begin
			w(3, {2'b00, k[1], 1'b1, 2'b00, k[0], 1'b0});
			repeat (3) @(negedge clk_sys);
			cfg_chk();
		end
		gv = 10'($urandom);
		for (int i = 9; i < 15; i++)
			w(i, gv[7:0]);
		w(15, {2'b11, gv[9:8], gv[9:8], gv[9:8]});
		repeat (3) @(negedge clk_sys);
		check(cfg.gyr_offsets, {3{gv}});
		check(cfg.acc_offsets, {3{gv[7:0]}});
		w(2, 8'h00);
		w(18, 8'ha0);
		w(2, 8'h02);
		w(18, 8'ha0);
		w(18, 8'hb0);
		w(18, 8'hb1);
		w(18, 8'hb6);
		repeat (3) @(negedge clk_sys);
		check(n_pr, e_pr);
		check(n_fl, e_fl);
		check(n_sr, e_sr);
		cfg_chk();
		rd_all();
		w(8, 8'h04);
		@(negedge clk_sys);
		sda_activity = 1'b1;
		repeat (31300) @(negedge clk_sys);
		check(n_wd, 0);
		i2c_mode = 1'b1;
		n = 0;
		while (wdt_timeout !== 1'b1 && n < 40000) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, sucr_pkg::SUCR_WDT_SHORT_CYC);
		sda_activity = 1'b0;
		i2c_mode = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(n_wd, 1);
		finish_test();
	end

	initial begin
		#4_000_000;
		bad_count++;
		finish_test();
	end
endmodule // sucr_regs_test
